// *** logic/slcis_status.sv ***
/*
 Sticky per-time-slot level-zero, level-one and channel-one ceiling flags,
 reached through the device's serial register port decoder.
 Assumes the update struct and the register request come from logic on
 ref_clk; the criteria and the threshold compare are done upstream.
*/
// Operation
// - Twelve level-zero flags at 0x0002, bit 0 slot A, write one clears.
// - Level-zero flag sets only on slot data update with criterion met.
// - Twelve level-one flags at 0x0003, bit 0 slot A, write one clears.
// - Level-one flag sets on slot update when criterion holds, else unchanged.
// - Ceiling flags at 0x0004, slot L bit 11, slot K bit 10, write one clears.
// - Ceiling flag sets on slot update when channel one exceeds threshold.
// - All three flag sets reset to zero.
// - Bits 15 to 12 reserved: read zero, writes ignored.
// - Ceiling flags for slots J down to A sit at bits 9 down to 0.
`timescale 1ns/10ps
`default_nettype none
`include "slcis_params.svh"
module slcis_status
    import slcis_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire slcis_update_s            upd,
    input  wire slcis_reg_req_s           req,
    output logic [`SLCIS_DATA_W-1:0]      rdata,
    output logic                          rvalid
);
    slcis_flags_t lev0_reg;
    slcis_flags_t lev1_reg;
    slcis_flags_t tc1_reg;
    slcis_flags_t lev0_set, lev1_set, tc1_set;
    slcis_flags_t lev0_clr, lev1_clr, tc1_clr;
    slcis_flags_t wr_ones;

    // Sets are only possible in the update cycle of the addressed slot
    assign lev0_set = upd.valid ? (upd.slot_onehot & upd.lev0_met)   : '0;
    assign lev1_set = upd.valid ? (upd.slot_onehot & upd.lev1_met)   : '0;
    assign tc1_set  = upd.valid ? (upd.slot_onehot & upd.ceil1_over) : '0;

    // Upper write bits are dropped here, so reserved bits cannot be touched
    assign wr_ones  = req.wdata[`SLCIS_NUM_SLOTS-1:0];
    assign lev0_clr = (req.wr && req.addr == `SLCIS_OFS_LEV0) ? wr_ones : '0;
    assign lev1_clr = (req.wr && req.addr == `SLCIS_OFS_LEV1) ? wr_ones : '0;
    assign tc1_clr  = (req.wr && req.addr == `SLCIS_OFS_TC1)  ? wr_ones : '0;

    // Level-zero flags; set wins so an event in the clear cycle survives
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lev0_reg <= `SLCIS_FLAG_RESET;
        end else begin
            lev0_reg <= (lev0_reg & ~lev0_clr) | lev0_set;
        end
    end

    // Level-one flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lev1_reg <= `SLCIS_FLAG_RESET;
        end else begin
            lev1_reg <= (lev1_reg & ~lev1_clr) | lev1_set;
        end
    end

    // Channel-one ceiling flags, bit index equals slot index
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tc1_reg <= `SLCIS_FLAG_RESET;
        end else begin
            tc1_reg <= (tc1_reg & ~tc1_clr) | tc1_set;
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    `SLCIS_OFS_LEV0: rdata <= {`SLCIS_RSVD_VALUE, lev0_reg};
                    `SLCIS_OFS_LEV1: rdata <= {`SLCIS_RSVD_VALUE, lev1_reg};
                    `SLCIS_OFS_TC1:  rdata <= {`SLCIS_RSVD_VALUE, tc1_reg};
                    default:         rdata <= '0;
                endcase
            end
        end
    end

    // Flag sets on an update with criterion met, whatever the host writes
    property p_lev0_set;
        @(posedge ref_clk) disable iff (!nrst)
        (upd.valid && |(upd.slot_onehot & upd.lev0_met)) |=>
            ((lev0_reg & $past(upd.slot_onehot & upd.lev0_met)) == $past(upd.slot_onehot & upd.lev0_met));
    endproperty
    a_lev0_set: assert property (p_lev0_set) else $error("level-zero flag not set on update");

    property p_lev0_no_spurious;
        @(posedge ref_clk) disable iff (!nrst)
        (lev0_set == '0) |=> ((lev0_reg & ~$past(lev0_reg)) == '0);
    endproperty
    a_lev0_no_spurious: assert property (p_lev0_no_spurious) else $error("level-zero flag rose without update");

    property p_lev1_hold;
        @(posedge ref_clk) disable iff (!nrst)
        (lev1_set == '0 && lev1_clr == '0) |=> (lev1_reg == $past(lev1_reg));
    endproperty
    a_lev1_hold: assert property (p_lev1_hold) else $error("level-one flags changed without cause");

    property p_lev1_clear;
        @(posedge ref_clk) disable iff (!nrst)
        (req.wr && req.addr == `SLCIS_OFS_LEV1 && lev1_set == '0) |=>
            ((lev1_reg & $past(wr_ones)) == '0);
    endproperty
    a_lev1_clear: assert property (p_lev1_clear) else $error("level-one write-one did not clear");

    property p_lev0_clear_keep;
        @(posedge ref_clk) disable iff (!nrst)
        (req.wr && req.addr == `SLCIS_OFS_LEV0) |=>
            ((lev0_reg & ~$past(wr_ones)) == ($past(lev0_reg | lev0_set) & ~$past(wr_ones)));
    endproperty
    a_lev0_clear_keep: assert property (p_lev0_clear_keep) else $error("write of zero altered a flag");

    property p_tc1_set_wins;
        @(posedge ref_clk) disable iff (!nrst)
        (|(tc1_set & tc1_clr)) |=> ((tc1_reg & $past(tc1_set)) == $past(tc1_set));
    endproperty
    a_tc1_set_wins: assert property (p_tc1_set_wins) else $error("ceiling set lost to clear");

    property p_tc1_slot_l;
        @(posedge ref_clk) disable iff (!nrst)
        (upd.valid && upd.slot_onehot[`SLCIS_SLOT_L_BIT] && upd.ceil1_over[`SLCIS_SLOT_L_BIT])
            ##1 (req.rd && req.addr == `SLCIS_OFS_TC1) |=> rvalid && rdata[`SLCIS_SLOT_L_BIT];
    endproperty
    a_tc1_slot_l: assert property (p_tc1_slot_l) else $error("slot L ceiling not at bit 11");

    property p_tc1_slot_a;
        @(posedge ref_clk) disable iff (!nrst)
        (upd.valid && upd.slot_onehot[`SLCIS_SLOT_A_BIT] && upd.ceil1_over[`SLCIS_SLOT_A_BIT]) |=> tc1_reg[`SLCIS_SLOT_A_BIT];
    endproperty
    a_tc1_slot_a: assert property (p_tc1_slot_a) else $error("slot A ceiling not at bit 0");

    property p_rsvd_zero;
        @(posedge ref_clk) disable iff (!nrst)
        rvalid |-> (rdata[`SLCIS_RSVD_MSB:`SLCIS_RSVD_LSB] == `SLCIS_RSVD_VALUE);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero");

    property p_reset_clear;
        @(posedge ref_clk)
        $rose(nrst) |-> (lev0_reg == '0 && lev1_reg == '0 && tc1_reg == '0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("flags not zero after reset");

    // Every update whose criterion holds must leave its flag raised, clear or no clear
    property p_lev1_set;
        @(posedge ref_clk) disable iff (!nrst)
        (upd.valid && |(upd.slot_onehot & upd.lev1_met)) |=>
            ((lev1_reg & $past(upd.slot_onehot & upd.lev1_met)) == $past(upd.slot_onehot & upd.lev1_met));
    endproperty
    a_lev1_set: assert property (p_lev1_set) else $error("level-one flag not set on update");

    property p_tc1_set;
        @(posedge ref_clk) disable iff (!nrst)
        (upd.valid && |(upd.slot_onehot & upd.ceil1_over)) |=>
            ((tc1_reg & $past(upd.slot_onehot & upd.ceil1_over)) == $past(upd.slot_onehot & upd.ceil1_over));
    endproperty
    a_tc1_set: assert property (p_tc1_set) else $error("ceiling flag not set on update");

    property p_tc1_no_spurious;
        @(posedge ref_clk) disable iff (!nrst)
        (tc1_set == '0) |=> ((tc1_reg & ~$past(tc1_reg)) == '0);
    endproperty
    a_tc1_no_spurious: assert property (p_tc1_no_spurious) else $error("ceiling flag rose without update");

    // Write-one clears must drop the written flags when no set competes
    property p_lev0_clear;
        @(posedge ref_clk) disable iff (!nrst)
        (req.wr && req.addr == `SLCIS_OFS_LEV0 && lev0_set == '0) |=>
            ((lev0_reg & $past(wr_ones)) == '0);
    endproperty
    a_lev0_clear: assert property (p_lev0_clear) else $error("level-zero write-one did not clear");

    property p_tc1_clear;
        @(posedge ref_clk) disable iff (!nrst)
        (req.wr && req.addr == `SLCIS_OFS_TC1 && tc1_set == '0) |=>
            ((tc1_reg & $past(wr_ones)) == '0);
    endproperty
    a_tc1_clear: assert property (p_tc1_clear) else $error("ceiling write-one did not clear");

    property p_lev0_set_wins;
        @(posedge ref_clk) disable iff (!nrst)
        (|(lev0_set & lev0_clr)) |=> ((lev0_reg & $past(lev0_set)) == $past(lev0_set));
    endproperty
    a_lev0_set_wins: assert property (p_lev0_set_wins) else $error("level-zero set lost to clear");

    // Read answer carries the flags as they stood at the read edge, upper bits zero
    property p_rd_lev0;
        @(posedge ref_clk) disable iff (!nrst)
        (req.rd && req.addr == `SLCIS_OFS_LEV0) |=> (rvalid && rdata == {`SLCIS_RSVD_VALUE, $past(lev0_reg)});
    endproperty
    a_rd_lev0: assert property (p_rd_lev0) else $error("level-zero read returned wrong word");

    property p_rd_lev1;
        @(posedge ref_clk) disable iff (!nrst)
        (req.rd && req.addr == `SLCIS_OFS_LEV1) |=> (rvalid && rdata == {`SLCIS_RSVD_VALUE, $past(lev1_reg)});
    endproperty
    a_rd_lev1: assert property (p_rd_lev1) else $error("level-one read returned wrong word");

    property p_rd_tc1;
        @(posedge ref_clk) disable iff (!nrst)
        (req.rd && req.addr == `SLCIS_OFS_TC1) |=> (rvalid && rdata == {`SLCIS_RSVD_VALUE, $past(tc1_reg)});
    endproperty
    a_rd_tc1: assert property (p_rd_tc1) else $error("ceiling read returned wrong word");

    property p_rd_unmapped;
        @(posedge ref_clk) disable iff (!nrst)
        (req.rd && req.addr != `SLCIS_OFS_LEV0 && req.addr != `SLCIS_OFS_LEV1
            && req.addr != `SLCIS_OFS_TC1) |=> (rvalid && rdata == '0);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read returned nonzero");
endmodule // slcis_status
`default_nettype wire

// *** logic/slcis_params.svh ***
/*
 Offsets, field layout and reset values for the slot status flag block.
 Assumes inclusion by bare name from the package and the design module.
*/
`ifndef SLCIS_PARAMS_SVH
`define SLCIS_PARAMS_SVH
`define SLCIS_ADDR_W        8
`define SLCIS_DATA_W        16
`define SLCIS_NUM_SLOTS     12
`define SLCIS_OFS_LEV0      8'h02
`define SLCIS_OFS_LEV1      8'h03
`define SLCIS_OFS_TC1       8'h04
`define SLCIS_FLAG_RESET    12'h000
`define SLCIS_RSVD_VALUE    4'h0
`define SLCIS_RSVD_MSB      15
`define SLCIS_RSVD_LSB      12
`define SLCIS_SLOT_A_BIT    0
`define SLCIS_SLOT_L_BIT    11
`endif

// *** logic/slcis_pkg.sv ***
/*
 Types shared by the slot status flag block.
 Assumes the params header is on the include path.
*/
`include "slcis_params.svh"
package slcis_pkg;
    typedef logic [`SLCIS_NUM_SLOTS-1:0] slcis_flags_t;
    // One data register update event, with per-slot criteria results
    typedef struct packed {
        logic         valid;
        slcis_flags_t slot_onehot;
        slcis_flags_t lev0_met;
        slcis_flags_t lev1_met;
        slcis_flags_t ceil1_over;
    } slcis_update_s;
    // Register port access from the serial interface decoder
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`SLCIS_ADDR_W-1:0] addr;
        logic [`SLCIS_DATA_W-1:0] wdata;
    } slcis_reg_req_s;
endpackage

// *** bench/slcis_host.sv ***
/*
 Host model: drives register reads and writes into the status block.
 Assumes one ref_clk domain and the read answer a cycle after the take edge.
*/
`timescale 1ns/10ps
`default_nettype none
module slcis_host
    import slcis_pkg::*;
(
    input  wire logic           ref_clk,
    output var  slcis_reg_req_s req,
    input  wire logic [15:0]    rdata,
    input  wire logic           rvalid
);
    initial req = '0;
    // Write only the serviced flags; address and data turn over once released
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
    endtask
    // Bounded wait; rvalid and rdata are taken at the edge that samples rvalid high
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d  = 16'h0000;
        @(posedge ref_clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk);
        req.rd   <= 1'b0;
        req.addr <= ~a;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge ref_clk);
            ok = (rvalid === 1'b1);
            d  = rdata;
        end
    endtask
endmodule // slcis_host
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 Self-checking bench for the slot status flags.
 Assumes the host model drives the register port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import slcis_pkg::*;
();
    logic           ref_clk   = 1'b0;
    logic           nrst      = 1'b0;
    slcis_update_s  upd       = '0;
    slcis_reg_req_s req;
    logic [15:0]    rdata;
    logic           rvalid;
    logic [15:0]    got;
    logic           ok;
    int             err_total = 0;
    int             checked   = 0;
    always #2 ref_clk = ~ref_clk;
    slcis_status u_dut (.ref_clk(ref_clk), .nrst(nrst), .upd(upd), .req(req), .rdata(rdata), .rvalid(rvalid));
    slcis_host u_host (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    task automatic close_out();
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // A lost answer strobe ends the run at once
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        u_host.rd(a, got, ok);
        if (!ok) begin
            err_total++;
            close_out();
        end else begin
            chk(got, e);
        end
    endtask
    // One update pulse; criteria outside the selected slots must be ignored
    task automatic pulse(input logic [11:0] oh, input logic [11:0] l0, input logic [11:0] l1, input logic [11:0] c1);
        @(posedge ref_clk);
        upd <= '{1'b1, oh, l0, l1, c1};
        @(posedge ref_clk);
        upd.valid <= 1'b0;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 2; i < 5; i++) rchk(i[7:0], 16'h0000);
        pulse(12'h801, 12'hfff, 12'h001, 12'h800);
        rchk(8'h02, 16'h0801);
        rchk(8'h03, 16'h0001);
        rchk(8'h04, 16'h0800);
        pulse(12'h000, 12'hfff, 12'hfff, 12'hfff);
        rchk(8'h02, 16'h0801);
        pulse(12'hfff, 12'h5a5, 12'h0f0, 12'h3ff);
        rchk(8'h04, 16'h0bff);
        u_host.wr(8'h02, 16'hf001);
        rchk(8'h02, 16'h0da4);
        u_host.wr(8'h03, 16'h0000);
        rchk(8'h03, 16'h00f1);
        u_host.wr(8'h03, 16'h0001);
        u_host.wr(8'h05, 16'hffff);
        rchk(8'h05, 16'h0000);
        rchk(8'h03, 16'h00f0);
        // Coincident set and clear on the same flag
        fork
            pulse(12'h800, 12'h000, 12'h000, 12'h800);
            u_host.wr(8'h04, 16'h0fff);
        join
        rchk(8'h04, 16'h0800);
        // Clear the ceiling flags, then read slot L in the cycle after its update
        u_host.wr(8'h04, 16'h0fff);
        rchk(8'h04, 16'h0000);
        fork
            pulse(12'h800, 12'h000, 12'h000, 12'h800);
            begin
                @(posedge ref_clk);
                rchk(8'h04, 16'h0800);
            end
        join
        // Level-zero set and write-one clear of slot A in one cycle
        fork
            pulse(12'h001, 12'h001, 12'h000, 12'h000);
            u_host.wr(8'h02, 16'h0001);
        join
        rchk(8'h02, 16'h0da5);
        // Mid-run reset must drop every pending flag
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 2; i < 5; i++) rchk(i[7:0], 16'h0000);
        close_out();
    end
endmodule // tb_top
`default_nettype wire
